/* File: pkg/board_glue_pkg.sv */
package board_glue_pkg;
  // ****************
  // Register map, byte addresses
  // ****************
  localparam logic [7:0] ip_service_off = 8'h00;
  localparam logic [7:0] slot_service_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] xbar_route_off = 8'h10;
  localparam logic [7:0] ip_event_off = 8'h30;
  localparam logic [7:0] vme_irq_off = 8'h34;
  localparam logic [7:0] irq_level_off = 8'h38;
  localparam logic [7:0] irq_dest_off = 8'h40;
  localparam logic [7:0] event_ack_off = 8'h44;
  localparam logic [7:0] irq_vector_off = 8'h60;

  // ****************
  // Field positions
  // ****************
  localparam int svc_reset_bit = 0;
  localparam int svc_analyse_bit = 1;
  localparam int svc_error_bit = 2;
  localparam int vme_irq_bit = 1;
  localparam int irq_dest_bit = 2;
  localparam int ip_event_bit = 0;
  localparam int irq_level_lsb = 0;
  localparam int xbar_b_lsb = 8;
  localparam int route_w = 6;

  // ****************
  // Reset values and bus answers
  // ****************
  localparam logic [2:0] svc_reset_val = 3'h0;
  localparam logic [2:0] irq_level_reset = 3'h0;
  localparam logic [7:0] irq_vector_reset = 8'h0f;
  localparam logic [5:0] route_reset = 6'h00;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Configuration up link destinations
  typedef enum logic [1:0] {
    cfg_to_adapter,
    cfg_to_front,
    cfg_to_rear
  } cfg_dest_t;
endpackage : board_glue_pkg

/* File: src/pin_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second; a change counts once 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : pin_sync3
`default_nettype wire

/* File: src/event_arm.sv */
`timescale 1ns/1ps
`default_nettype none
module event_arm (
  input wire logic aclk,
  input wire logic rst,
  input wire logic request,
  input wire logic rearm,
  output logic event_pulse,
  output logic armed
);
  // One event per arming; a rearm in the same cycle as an event keeps
  // the block armed so that the acknowledge is never lost
  always_ff @(posedge aclk) begin
    if (rst) begin
      armed <= 1'b1;
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= request && armed;
      if (rearm) begin
        armed <= 1'b1; // R20
      end else if (request && armed) begin
        armed <= 1'b0; // R16
      end
    end
  end
endmodule : event_arm
`default_nettype wire

/* File: src/board_service_irq.sv */
// What this block does
// R1 - Crossbar may join group A links only to group B links.
// R2 - Each link's input goes through one crossbar, output through the other.
// R3 - Never use rear and front paths of a shared link together.
// R4 - Config up/down link steered by front and port selectors.
// R5 - Interface processor services are register bits OR upper port inputs.
// R6 - Slot 0 services are processor services OR slot register bits.
// R7 - Slot 0 services are also driven on the lower service port.
// R8 - Slots 1-7 take slot 0 subsystem port or slot 0 source.
// R9 - Link adapter and config processor reset by slot 0 reset.
// R10 - Crossbar reset on every config processor external memory write.
// R11 - Power-on or VME reset resets every part of the board. The pin synchronisers here reset on aresetn only.
// R12 - VME request raised while the interrupt bit is set.
// R13 - VME request line follows the programmed interrupt level.
// R14 - Acknowledge cycle answered with the vector register contents.
// R15 - Event bit set signals events to the interface processor.
// R16 - Processor must acknowledge before the next event is delivered.
// R17 - Adapter interrupt steered by the destination register.
// R18 - Interrupt level 1 to 7; zero disables VME interrupts.
// R19 - Destination set: processor; clear: VME bus.
// R20 - Any write to the acknowledge register re-arms events.
// R21 - Answer acknowledge only on matching level while pending.
`timescale 1ns/1ps
`default_nettype none
module board_service_irq (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interface processor write port to the slot register (same clock)
  input wire logic ip_slot_wr,
  input wire logic [2:0] ip_slot_data,
  // Pins
  input wire logic vme_sysreset,
  input wire logic [2:0] upper_svc_in,
  input wire logic [2:0] slot0_subsys_in,
  input wire logic front_config_selector,
  input wire logic config_port_selector,
  input wire logic slot_hierarchy_selector,
  input wire logic cfg_mem_write,
  input wire logic adapter_irq,
  input wire logic vme_iack,
  input wire logic [2:0] vme_iack_level,
  input wire logic vme_iackin,
  // Services out
  output logic [2:0] ip_svc,
  output logic [2:0] slot0_svc,
  output logic [2:0] lower_svc_out,
  output logic [2:0] slots_svc,
  output logic adapter_reset,
  output logic cfg_proc_reset,
  output logic xbar_reset,
  // Configuration link steering
  output logic [1:0] cfg_up_link,
  output logic cfg_down_link,
  // Crossbar programming
  output logic xbar_prog,
  output logic [5:0] xbar_in_src,
  output logic [5:0] xbar_in_dst,
  output logic [5:0] xbar_out_src,
  output logic [5:0] xbar_out_dst,
  // Interrupts
  output logic [7:1] vme_irq_n,
  output logic [7:0] iack_data,
  output logic iack_data_oe,
  output logic iack_dtack,
  output logic vme_iackout,
  output logic ip_event,
  output logic ip_adapter_irq
);
  // ****************
  // Pin synchronisers
  // ****************
  localparam int n_pins = 17;
  logic [n_pins-1:0] pin_raw;
  logic [n_pins-1:0] pin_s;
  assign pin_raw = {vme_iackin, vme_iack_level, vme_iack, adapter_irq,
    cfg_mem_write, slot_hierarchy_selector, config_port_selector,
    front_config_selector, slot0_subsys_in, upper_svc_in, vme_sysreset};

  for (genvar i = 0; i < n_pins; i++) begin : g_sync
    pin_sync3 u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(pin_raw[i]),
      .level(pin_s[i])
    );
  end

  logic sysrst_s;
  logic [2:0] upper_s;
  logic [2:0] subsys_s;
  logic front_s;
  logic port_s;
  logic hier_s;
  logic memwr_s;
  logic adapter_s;
  logic iack_s;
  logic [2:0] iack_lvl_s;
  logic iackin_s;
  assign sysrst_s = pin_s[0];
  assign upper_s = pin_s[3:1];
  assign subsys_s = pin_s[6:4];
  assign front_s = pin_s[7];
  assign port_s = pin_s[8];
  assign hier_s = pin_s[9];
  assign memwr_s = pin_s[10];
  assign adapter_s = pin_s[11];
  assign iack_s = pin_s[12];
  assign iack_lvl_s = pin_s[15:13];
  assign iackin_s = pin_s[16];

  // Power-on or VME reset resets everything on the board except the pin synchronisers, which only aresetn resets
  logic rst;
  assign rst = !aresetn || sysrst_s; // R11

  // ****************
  // Registers
  // ****************
  logic [2:0] ip_reg_q;
  logic [2:0] slot_reg_q;
  logic [11:0] route_q;
  logic ip_event_q;
  logic vme_irq_q;
  logic [2:0] irq_level_q;
  logic irq_dest_q;
  logic [7:0] irq_vector_q;
  logic ev_armed;
  logic ev_pulse;

  // ****************
  // AXI4-Lite write path
  // ****************
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_b0;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_b0 = wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  logic wr_mapped;
  always_comb begin
    case (wr_addr)
      board_glue_pkg::ip_service_off,
      board_glue_pkg::slot_service_off,
      board_glue_pkg::xbar_route_off,
      board_glue_pkg::ip_event_off,
      board_glue_pkg::vme_irq_off,
      board_glue_pkg::irq_level_off,
      board_glue_pkg::irq_dest_off,
      board_glue_pkg::event_ack_off,
      board_glue_pkg::irq_vector_off: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= board_glue_pkg::resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? board_glue_pkg::resp_okay
                               : board_glue_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_go && wr_b0;

  always_ff @(posedge aclk) begin
    if (rst) begin
      ip_reg_q <= board_glue_pkg::svc_reset_val;
    end else if (wr_en && wr_addr == board_glue_pkg::ip_service_off) begin
      ip_reg_q <= wr_data[2:0];
    end
  end

  // Both VME and the interface processor may write; VME wins a tie
  always_ff @(posedge aclk) begin
    if (rst) begin
      slot_reg_q <= board_glue_pkg::svc_reset_val;
    end else if (wr_en && wr_addr == board_glue_pkg::slot_service_off) begin
      slot_reg_q <= wr_data[2:0]; // R6
    end else if (ip_slot_wr) begin
      slot_reg_q <= ip_slot_data; // R6
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      ip_event_q <= 1'b0;
      vme_irq_q <= 1'b0;
      irq_level_q <= board_glue_pkg::irq_level_reset;
      irq_dest_q <= 1'b0;
      irq_vector_q <= board_glue_pkg::irq_vector_reset;
    end else if (wr_en) begin
      case (wr_addr)
        board_glue_pkg::ip_event_off:
          ip_event_q <= wr_data[board_glue_pkg::ip_event_bit];
        board_glue_pkg::vme_irq_off:
          vme_irq_q <= wr_data[board_glue_pkg::vme_irq_bit];
        board_glue_pkg::irq_level_off:
          irq_level_q <= wr_data[board_glue_pkg::irq_level_lsb +: 3];
        board_glue_pkg::irq_dest_off:
          irq_dest_q <= wr_data[board_glue_pkg::irq_dest_bit];
        board_glue_pkg::irq_vector_off:
          irq_vector_q <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // ****************
  // Crossbar programming
  // ****************
  // One request names a group A link and a group B link; the in path is
  // set on one crossbar and the out path on the other, never in series.
  always_ff @(posedge aclk) begin
    if (rst) begin
      xbar_prog <= 1'b0;
      xbar_in_src <= board_glue_pkg::route_reset;
      xbar_in_dst <= board_glue_pkg::route_reset;
      xbar_out_src <= board_glue_pkg::route_reset;
      xbar_out_dst <= board_glue_pkg::route_reset;
    end else begin
      xbar_prog <= wr_en && wr_addr == board_glue_pkg::xbar_route_off;
      if (wr_en && wr_addr == board_glue_pkg::xbar_route_off) begin
        xbar_in_src <= wr_data[board_glue_pkg::route_w-1:0]; // R2
        xbar_in_dst <= wr_data[board_glue_pkg::xbar_b_lsb +:
                               board_glue_pkg::route_w]; // R2
        xbar_out_src <= wr_data[board_glue_pkg::xbar_b_lsb +:
                                board_glue_pkg::route_w]; // R2
        xbar_out_dst <= wr_data[board_glue_pkg::route_w-1:0]; // R2
      end
    end
  end

  assign route_q = {xbar_in_dst, xbar_in_src};

  // ****************
  // System services
  // ****************
  logic [2:0] ip_svc_d;
  logic [2:0] slot0_svc_d;
  assign ip_svc_d = ip_reg_q | upper_s; // R5
  assign slot0_svc_d = ip_svc_d | slot_reg_q; // R6

  always_ff @(posedge aclk) begin
    if (rst) begin
      ip_svc <= 3'h1;
      slot0_svc <= 3'h1;
      lower_svc_out <= 3'h1;
      slots_svc <= 3'h1;
      adapter_reset <= 1'b1;
      cfg_proc_reset <= 1'b1;
      xbar_reset <= 1'b1;
    end else begin
      ip_svc <= ip_svc_d;
      slot0_svc <= slot0_svc_d;
      lower_svc_out <= slot0_svc_d; // R7
      slots_svc <= hier_s ? subsys_s : slot0_svc_d; // R8
      adapter_reset <= slot0_svc_d[board_glue_pkg::svc_reset_bit]; // R9
      cfg_proc_reset <= slot0_svc_d[board_glue_pkg::svc_reset_bit]; // R9
      xbar_reset <= memwr_s; // R10
    end
  end

  // ****************
  // Configuration link steering
  // ****************
  always_ff @(posedge aclk) begin
    if (rst) begin
      cfg_up_link <= board_glue_pkg::cfg_to_adapter;
      cfg_down_link <= 1'b0;
    end else begin
      if (front_s) begin
        cfg_up_link <= board_glue_pkg::cfg_to_adapter; // R4
      end else if (port_s) begin
        cfg_up_link <= board_glue_pkg::cfg_to_front; // R4
      end else begin
        cfg_up_link <= board_glue_pkg::cfg_to_rear; // R4
      end
      cfg_down_link <= port_s; // R4
    end
  end

  // ****************
  // VME interrupt and acknowledge
  // ****************
  logic pending;
  logic lvl_ok;
  assign pending = vme_irq_q || (adapter_s && !irq_dest_q); // R12 R19
  assign lvl_ok = irq_level_q != 3'h0; // R18

  always_ff @(posedge aclk) begin
    if (rst) begin
      vme_irq_n <= 7'h7f;
    end else begin
      for (int l = 1; l <= 7; l++) begin
        vme_irq_n[l] <= !(pending && lvl_ok && irq_level_q == 3'(l)); // R13
      end
    end
  end

  // Mismatched or idle acknowledges go down the daisy chain
  logic iack_mine;
  assign iack_mine = iack_s && iackin_s && pending && lvl_ok &&
                     iack_lvl_s == irq_level_q; // R21
  always_ff @(posedge aclk) begin
    if (rst) begin
      iack_data <= 8'h00;
      iack_data_oe <= 1'b0;
      iack_dtack <= 1'b0;
      vme_iackout <= 1'b0;
    end else begin
      iack_data <= iack_mine ? irq_vector_q : 8'h00; // R14
      iack_data_oe <= iack_mine; // R14
      iack_dtack <= iack_mine; // R14
      vme_iackout <= iack_s && iackin_s && !iack_mine; // R21
    end
  end

  // ****************
  // Interface processor events
  // ****************
  logic ev_req;
  assign ev_req = ip_event_q || (adapter_s && irq_dest_q); // R15 R17

  event_arm u_event (
    .aclk(aclk),
    .rst(rst),
    .request(ev_req),
    .rearm(wr_go && wr_addr == board_glue_pkg::event_ack_off), // R20
    .event_pulse(ev_pulse),
    .armed(ev_armed)
  );

  always_ff @(posedge aclk) begin
    if (rst) begin
      ip_event <= 1'b0;
      ip_adapter_irq <= 1'b0;
    end else begin
      ip_event <= ev_pulse; // R15
      ip_adapter_irq <= adapter_s && irq_dest_q; // R17
    end
  end

  // ****************
  // AXI4-Lite read path
  // ****************
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      board_glue_pkg::ip_service_off: rd_val[2:0] = ip_reg_q;
      board_glue_pkg::slot_service_off: rd_val[2:0] = slot_reg_q;
      board_glue_pkg::status_off:
        rd_val[10:0] = {ev_armed, pending, hier_s, port_s, front_s,
                        subsys_s, upper_s};
      board_glue_pkg::xbar_route_off:
        rd_val[13:0] = {route_q[11:6], 2'h0, route_q[5:0]};
      board_glue_pkg::ip_event_off: rd_val[0] = ip_event_q;
      board_glue_pkg::vme_irq_off: rd_val[1] = vme_irq_q;
      board_glue_pkg::irq_level_off: rd_val[2:0] = irq_level_q;
      board_glue_pkg::irq_dest_off: rd_val[2] = irq_dest_q;
      board_glue_pkg::event_ack_off: rd_val = 32'h0000_0000;
      board_glue_pkg::irq_vector_off: rd_val[7:0] = irq_vector_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= board_glue_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? board_glue_pkg::resp_okay
                           : board_glue_pkg::resp_slverr;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : board_service_irq
`default_nettype wire

/* File: tb/vme_iack_master.sv */
`timescale 1ns/1ps
`default_nettype none
module vme_iack_master (
  input wire logic aclk,
  input wire logic go,
  input wire logic [2:0] lvl,
  input wire logic iack_dtack,
  input wire logic vme_iackout,
  input wire logic iack_data_oe,
  input wire logic [7:0] iack_data,
  output logic vme_iack,
  output logic [2:0] vme_iack_level,
  output logic vme_iackin,
  output logic busy,
  output logic answered,
  output logic [7:0] vec
);
  // ****************
  // Acknowledge cycle
  // ****************
  initial begin
    {vme_iack, vme_iackin, busy, answered} = 4'h0;
    vme_iack_level = 3'h0;
    vec = 8'h00;
  end
  // Held until an answer or a pass down the daisy chain; released level lines show the inverse so
  // a stale level can never pass for a fresh cycle
  always @(posedge aclk) begin
    if (go) begin
      {vme_iack, vme_iackin, busy} <= 3'h7;
      vme_iack_level <= lvl;
    end else if (busy && (iack_dtack || vme_iackout)) begin
      {vme_iack, vme_iackin, busy} <= 3'h0;
      vme_iack_level <= ~vme_iack_level;
      answered <= iack_dtack;
      vec <= iack_data_oe ? iack_data : 8'h00;
    end
  end
endmodule : vme_iack_master
`default_nettype wire

/* File: tb/board_service_irq_props.sv */
`timescale 1ns/1ps
`default_nettype none
module board_service_irq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] slot0_svc,
  input wire logic [2:0] lower_svc_out,
  input wire logic adapter_reset,
  input wire logic xbar_reset,
  input wire logic [1:0] cfg_up_link,
  input wire logic cfg_down_link,
  input wire logic xbar_prog,
  input wire logic [5:0] xbar_in_src,
  input wire logic [5:0] xbar_in_dst,
  input wire logic [5:0] xbar_out_src,
  input wire logic [5:0] xbar_out_dst,
  input wire logic [7:1] vme_irq_n,
  input wire logic iack_data_oe,
  input wire logic iack_dtack,
  input wire logic vme_iackout,
  input wire logic ip_event
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  lower_port_a: assert property (lower_svc_out == slot0_svc)
    else $error("lower port");
  slot_reset_a: assert property (adapter_reset == slot0_svc[0])
    else $error("adapter reset");
  power_reset_a: assert property ($rose(aresetn) |->
    adapter_reset && xbar_reset && slot0_svc == 3'h1)
    else $error("reset hold");
  front_down_a: assert property (
    cfg_up_link == 2'h1 |-> cfg_down_link)
    else $error("front down link");
  rear_down_a: assert property (
    cfg_up_link == 2'h2 |-> !cfg_down_link)
    else $error("rear down link");
  one_line_a: assert property ($countones(~vme_irq_n) <= 1)
    else $error("request lines");
  iack_answer_a: assert property (iack_dtack |->
    iack_data_oe && !vme_iackout && vme_irq_n != 7'h7f)
    else $error("stray answer");
  event_once_a: assert property (ip_event |=> !ip_event)
    else $error("double event");
  xbar_pair_a: assert property (xbar_prog |->
    xbar_in_src == xbar_out_dst && xbar_in_dst == xbar_out_src)
    else $error("crossbar pair");
endmodule : board_service_irq_props
bind board_service_irq board_service_irq_props chk_u (
  .aclk, .aresetn, .slot0_svc, .lower_svc_out, .adapter_reset, .xbar_reset,
  .cfg_up_link, .cfg_down_link, .xbar_prog, .xbar_in_src, .xbar_in_dst,
  .xbar_out_src, .xbar_out_dst, .vme_irq_n, .iack_data_oe, .iack_dtack,
  .vme_iackout, .ip_event
);
`default_nettype wire

/* File: tb/tb_board_service_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_board_service_irq;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, ip_slot_wr, vme_sysreset, adapter_irq;
  logic front_config_selector, config_port_selector, cfg_mem_write;
  logic slot_hierarchy_selector, vme_iack, vme_iackin, iack_go, busy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cfg_down_link, xbar_prog, iack_data_oe, answered;
  logic iack_dtack, vme_iackout, ip_event, ip_adapter_irq, xbar_reset;
  logic adapter_reset, cfg_proc_reset;
  logic [1:0] s_axi_bresp, s_axi_rresp, cfg_up_link, resp;
  logic [2:0] ip_slot_data, upper_svc_in, slot0_subsys_in, vme_iack_level;
  logic [2:0] ip_svc, slot0_svc, lower_svc_out, slots_svc, iack_lvl;
  logic [3:0] s_axi_wstrb;
  logic [5:0] xbar_in_src, xbar_in_dst, xbar_out_src, xbar_out_dst;
  logic [7:1] vme_irq_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, iack_data, vec;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  int errors = 0, n_checks = 0, cycles = 0, n_events = 0;
  board_service_irq dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ip_slot_wr, .ip_slot_data, .vme_sysreset, .upper_svc_in,
    .slot0_subsys_in, .front_config_selector, .config_port_selector,
    .slot_hierarchy_selector, .cfg_mem_write, .adapter_irq, .vme_iack,
    .vme_iack_level, .vme_iackin, .ip_svc, .slot0_svc, .lower_svc_out,
    .slots_svc, .adapter_reset, .cfg_proc_reset, .xbar_reset, .cfg_up_link,
    .cfg_down_link, .xbar_prog, .xbar_in_src, .xbar_in_dst, .xbar_out_src,
    .xbar_out_dst, .vme_irq_n, .iack_data, .iack_data_oe, .iack_dtack,
    .vme_iackout, .ip_event, .ip_adapter_irq
  );
  vme_iack_master vme_u (
    .aclk, .go(iack_go), .lvl(iack_lvl), .iack_dtack, .vme_iackout,
    .iack_data_oe, .iack_data, .vme_iack, .vme_iack_level, .vme_iackin,
    .busy, .answered, .vec
  );
  // ****************
  // Bus tasks and sequence
  // ****************
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (ip_event === 1'h1) n_events++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
  endtask : rd
  task automatic iack(input logic [2:0] l);
    iack_lvl <= l;
    iack_go <= 1'h1;
    @(posedge aclk);
    iack_go <= 1'h0;
    do @(posedge aclk); while (busy);
    repeat (10) @(posedge aclk);
  endtask : iack
  initial begin
    aclk = 1'h0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, ip_slot_wr, vme_sysreset, front_config_selector,
      config_port_selector, adapter_irq, slot_hierarchy_selector,
      cfg_mem_write, iack_go} <= 14'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ip_slot_data, upper_svc_in,
      slot0_subsys_in, iack_lvl} <= 60'h0;
    s_axi_wstrb <= 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    rd(board_glue_pkg::irq_vector_off);
    chk(rdat, 32'h0000000f, "vector reset");
    wr(8'h0c, 32'h1);
    chk(resp, board_glue_pkg::resp_slverr, "unmapped write");
    wr(board_glue_pkg::ip_service_off, 32'h2);
    upper_svc_in <= 3'h4;
    ip_slot_wr <= 1'h1;
    ip_slot_data <= 3'h1;
    @(posedge aclk);
    ip_slot_wr <= 1'h0;
    repeat (8) @(posedge aclk);
    chk({ip_svc, slot0_svc, lower_svc_out}, 9'h1bf, "services");
    chk({slots_svc, cfg_proc_reset}, 4'hf, "flat slots");
    slot_hierarchy_selector <= 1'h1;
    slot0_subsys_in <= 3'h5;
    upper_svc_in <= 3'h0;
    wr(board_glue_pkg::slot_service_off, 32'h0);
    wr(board_glue_pkg::ip_service_off, 32'h0);
    repeat (8) @(posedge aclk);
    chk({slots_svc, slot0_svc, adapter_reset}, 7'h50, "hierarchy");
    for (int i = 0; i < 4; i++) begin
      front_config_selector <= i[1];
      config_port_selector <= i[0];
      repeat (8) @(posedge aclk);
      chk(cfg_up_link, i[1] ? 2'h0 : (i[0] ? 2'h1 : 2'h2), "up link");
      chk(cfg_down_link, i[0], "down link");
    end
    cfg_mem_write <= 1'h1;
    wr(board_glue_pkg::xbar_route_off, 32'h2a15);
    repeat (8) @(posedge aclk);
    chk(xbar_reset, 1'h1, "crossbar reset");
    chk({xbar_in_src, xbar_in_dst}, 12'h56a, "in crossbar");
    chk({xbar_out_src, xbar_out_dst}, 12'ha95, "out crossbar");
    cfg_mem_write <= 1'h0;
    repeat (8) @(posedge aclk);
    chk(xbar_reset, 1'h0, "crossbar run");
    wr(board_glue_pkg::irq_vector_off, 32'ha5);
    wr(board_glue_pkg::vme_irq_off, 32'h2);
    for (int l = 7; l >= 0; l--) begin
      wr(board_glue_pkg::irq_level_off, l);
      repeat (3) @(posedge aclk);
      chk(vme_irq_n, l ? 7'(~(7'h01 << (l - 1))) : 7'h7f, "line");
    end
    wr(board_glue_pkg::irq_level_off, 32'h3);
    repeat (3) @(posedge aclk);
    iack(3'h3);
    chk({answered, vec}, 9'h1a5, "vector answer");
    iack(3'h5);
    chk(answered, 1'h0, "other level");
    wr(board_glue_pkg::vme_irq_off, 32'h0);
    repeat (3) @(posedge aclk);
    chk(vme_irq_n, 7'h7f, "withdrawn");
    iack(3'h3);
    chk(answered, 1'h0, "not pending");
    wr(board_glue_pkg::ip_event_off, 32'h1);
    repeat (20) @(posedge aclk);
    chk(n_events, 1, "one event");
    wr(board_glue_pkg::event_ack_off, 32'h0);
    repeat (20) @(posedge aclk);
    chk(n_events, 2, "event after ack");
    wr(board_glue_pkg::ip_event_off, 32'h0);
    wr(board_glue_pkg::event_ack_off, 32'h0);
    repeat (20) @(posedge aclk);
    chk(n_events, 2, "events stopped");
    wr(board_glue_pkg::irq_level_off, 32'h2);
    wr(board_glue_pkg::irq_dest_off, 32'h4);
    adapter_irq <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({ip_adapter_irq, vme_irq_n}, 8'hff, "to processor");
    wr(board_glue_pkg::irq_dest_off, 32'h0);
    repeat (3) @(posedge aclk);
    chk({ip_adapter_irq, vme_irq_n}, 8'h7d, "to bus");
    adapter_irq <= 1'h0;
    vme_sysreset <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({adapter_reset, xbar_reset}, 2'h3, "system reset");
    vme_sysreset <= 1'h0;
    repeat (8) @(posedge aclk);
    rd(board_glue_pkg::irq_vector_off);
    chk(rdat, 32'h0000000f, "vector after reset");
    give_verdict();
  end
endmodule : tb_board_service_irq
`default_nettype wire
